// ---- design/hbs_sequencer.sv ----
// holding brake sequencer: start, stop and coast handling of the motor brake
`timescale 1ns/100ps
`include "hbs_params.svh"
module hbs_sequencer #(
	parameter int TICK_CYCLES = `HBS_TICK_CYCLES
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic cfg_load_i,
	input wire hbs_pkg::hbs_cfg_s cfg_i,
	input wire logic run_cmd_i,
	input wire logic ramp_stop_command_i,
	input wire logic quick_stop_command_i,
	input wire logic coast_stop_command_i,
	input wire logic signed [15:0] speed_setpoint_i,
	input wire logic signed [15:0] speed_actual_i,
	input wire logic [2:0] aux_pin_i,
	output hbs_pkg::hbs_drv_s drive_o,
	output logic brake_open_o,
	output logic brake_route_o,
	output logic brake_open_status_bit_o,
	output logic slip_comp_en_o,
	output logic [7:0] brake_start_frequency_o,
	output logic [1:0] brake_start_torque_source_o,
	output hbs_pkg::hbs_state_e state_o
);

	if (TICK_CYCLES < 2) begin
		$error("hbs_sequencer: TICK_CYCLES too small");
	end

	// ****************************************
	// helpers
	// ****************************************
	function automatic logic below_thr(input logic signed [15:0] spd, input logic [15:0] thr);
		logic [15:0] mag;
		mag = spd[15] ? 16'(-spd) : 16'(spd);
		return mag < thr;
	endfunction

	// source 0 is a constant zero, 1 to 3 pick a synchronised pin
	function automatic logic pick_src(input logic [1:0] sel, input logic [2:0] pins);
		logic v;
		v = 1'b0;
		if (sel != 2'h0) begin
			v = pins[sel - 2'h1];
		end
		return v;
	endfunction

	// ****************************************
	// configuration store
	// ****************************************
	// defaults live in the flop itself, so no cycle runs on an all-zero config unless cfg_load_i loads one
	localparam hbs_pkg::hbs_cfg_s CFG_RST = '{
		mode: hbs_pkg::hbs_mode_e'(`HBS_MODE_RST),
		ctrl_mode: `HBS_CTRL_MODE_RST,
		excite_ms: `HBS_EXCITE_RST,
		open_ms: `HBS_OPEN_DLY_RST,
		close_ms: `HBS_CLOSE_DLY_RST,
		mon_ms: `HBS_MON_TIME_RST,
		pc_ms: `HBS_PC_DLY_RST,
		thresh_rpm: `HBS_THRESH_RST,
		fopen_src: `HBS_SRC_RST,
		fclose_src: `HBS_SRC_RST,
		start_freq: `HBS_START_FREQ_RST,
		torque_src: `HBS_SRC_RST
	};
	hbs_pkg::hbs_cfg_s cfg_q;
	hbs_pkg::hbs_cfg_s cfg;

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			cfg_q <= CFG_RST;
		end else if (cfg_load_i) begin
			cfg_q <= cfg_i;
		end
	end

	assign cfg = cfg_q;

	// ****************************************
	// pin synchronisers
	// ****************************************
	logic [2:0] aux_meta_q;
	logic [2:0] aux_sync_q;

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			aux_meta_q <= 3'h0;
			aux_sync_q <= 3'h0;
		end else begin
			aux_meta_q <= aux_pin_i;
			aux_sync_q <= aux_meta_q;
		end
	end

	wire fopen_w = pick_src(cfg.fopen_src, aux_sync_q);
	wire fclose_w = pick_src(cfg.fclose_src, aux_sync_q);

	// ****************************************
	// decode
	// ****************************************
	hbs_pkg::hbs_state_e state_q;
	hbs_pkg::hbs_state_e state_d;
	wire seq_en = (cfg.mode == hbs_pkg::HBS_MODE_SEQ) || (cfg.mode == hbs_pkg::HBS_MODE_ROUTED);
	wire stop_req = ramp_stop_command_i || quick_stop_command_i;
	wire st_stop = (state_q == hbs_pkg::HBS_ST_STOP);
	wire sp_below = below_thr(speed_setpoint_i, cfg.thresh_rpm);
	wire act_below = below_thr(speed_actual_i, cfg.thresh_rpm);
	wire vector_mode = (cfg.ctrl_mode >= `HBS_VECTOR_MIN);

	logic sp_below_q;
	logic act_below_q;
	logic seq_start;
	logic [19:0] seq_dur;
	wire seq_done;
	wire mon_busy;
	wire mon_done;
	wire pc_done;

	// each timer starts on the first STOP cycle that finds its speed below the threshold
	wire mon_start = st_stop && sp_below && !sp_below_q;
	wire pc_start = st_stop && act_below && !act_below_q;
	wire stand_done = mon_done || pc_done;

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			sp_below_q <= 1'b0;
			act_below_q <= 1'b0;
		end else begin
			sp_below_q <= st_stop && sp_below;
			act_below_q <= st_stop && act_below;
		end
	end

	// ****************************************
	// timers
	// ****************************************
	hbs_timer #(
		.WIDTH(20),
		.TICK_CYCLES(TICK_CYCLES)
	) u_seq_tmr (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.start_i(seq_start),
		.clear_i(coast_stop_command_i),
		.dur_i(seq_dur),
		.busy_o(),
		.done_o(seq_done)
	);

	hbs_timer #(
		.WIDTH(20),
		.TICK_CYCLES(TICK_CYCLES)
	) u_mon_tmr (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.start_i(mon_start),
		.clear_i(!st_stop),
		.dur_i(cfg.mon_ms),
		.busy_o(mon_busy),
		.done_o(mon_done)
	);

	hbs_timer #(
		.WIDTH(20),
		.TICK_CYCLES(TICK_CYCLES)
	) u_pc_tmr (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.start_i(pc_start),
		.clear_i(!st_stop),
		.dur_i(cfg.pc_ms),
		.busy_o(),
		.done_o(pc_done)
	);

	// ****************************************
	// sequence
	// ****************************************
	always_comb begin
		state_d = state_q;
		seq_start = 1'b0;
		seq_dur = cfg.excite_ms;
		case (state_q)
			hbs_pkg::HBS_ST_IDLE: begin
				if (run_cmd_i && !stop_req) begin
					state_d = hbs_pkg::HBS_ST_MAG;
					seq_start = 1'b1;
				end
			end
			// brake opens once excitation time is done; a stop during excitation goes to STOP, which opens it at once
			hbs_pkg::HBS_ST_MAG: begin
				if (stop_req) begin
					state_d = hbs_pkg::HBS_ST_STOP;
				end else if (seq_done && seq_en) begin
					state_d = hbs_pkg::HBS_ST_OPEN;
					seq_start = 1'b1;
					seq_dur = cfg.open_ms;
				end else if (seq_done) begin
					state_d = hbs_pkg::HBS_ST_RUN;
				end
			end
			// hold standstill through the opening delay
			hbs_pkg::HBS_ST_OPEN: begin
				if (stop_req) begin
					state_d = hbs_pkg::HBS_ST_STOP;
				end else if (seq_done) begin
					state_d = hbs_pkg::HBS_ST_RUN;
				end
			end
			// a stop goes through deceleration first
			hbs_pkg::HBS_ST_RUN: begin
				if (stop_req) begin
					state_d = hbs_pkg::HBS_ST_STOP;
				end
			end
			// first expiring standstill timer closes the brake
			hbs_pkg::HBS_ST_STOP: begin
				if (stand_done && seq_en) begin
					state_d = hbs_pkg::HBS_ST_CLOSE;
					seq_start = 1'b1;
					seq_dur = cfg.close_ms;
				end else if (stand_done) begin
					state_d = hbs_pkg::HBS_ST_IDLE;
				end
			end
			// motor stays on for the closing delay
			hbs_pkg::HBS_ST_CLOSE: begin
				if (seq_done) begin
					state_d = hbs_pkg::HBS_ST_IDLE;
				end
			end
			default: begin
				state_d = hbs_pkg::HBS_ST_IDLE;
			end
		endcase
		// coast stop overrides every state at once
		if (coast_stop_command_i) begin
			state_d = hbs_pkg::HBS_ST_IDLE;
			seq_start = 1'b0;
		end
	end

	// ****************************************
	// output decode
	// ****************************************
	wire seq_open_d = seq_en && ((state_d == hbs_pkg::HBS_ST_OPEN) ||
		(state_d == hbs_pkg::HBS_ST_RUN) || (state_d == hbs_pkg::HBS_ST_STOP));
	// mode selects disabled, sequenced, always open or routed
	wire mode_open_d = (cfg.mode == hbs_pkg::HBS_MODE_OPEN) || seq_open_d;
	// close wins over open: a dropped load is worse than a dragging brake
	wire brake_d = !fclose_w && (fopen_w || mode_open_d);
	wire starting_d = (state_d == hbs_pkg::HBS_ST_OPEN);

	hbs_pkg::hbs_drv_s drive_d;
	assign drive_d.motor_on = (state_d != hbs_pkg::HBS_ST_IDLE);
	assign drive_d.hold_zero = (state_d == hbs_pkg::HBS_ST_MAG) || starting_d;
	assign drive_d.ramp_en = (state_d == hbs_pkg::HBS_ST_RUN);
	assign drive_d.decel = (state_d == hbs_pkg::HBS_ST_STOP);

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			state_q <= hbs_pkg::HBS_ST_IDLE;
			drive_o <= '0;
			brake_open_o <= 1'b0;
			brake_route_o <= 1'b0;
			brake_open_status_bit_o <= 1'b0;
			slip_comp_en_o <= 1'b0;
			brake_start_frequency_o <= 8'h00;
			brake_start_torque_source_o <= 2'h0;
		end else begin
			state_q <= state_d;
			drive_o <= drive_d;
			// routed mode drives the interconnect, not the relay
			brake_open_o <= brake_d && (cfg.mode != hbs_pkg::HBS_MODE_ROUTED);
			brake_route_o <= brake_d && (cfg.mode == hbs_pkg::HBS_MODE_ROUTED);
			brake_open_status_bit_o <= brake_d;
			// nonzero start frequency enables slip compensation
			slip_comp_en_o <= (cfg.start_freq != 8'h00);
			brake_start_frequency_o <= starting_d ? cfg.start_freq : 8'h00;
			// torque source only used in vector control
			brake_start_torque_source_o <= (starting_d && vector_mode) ? cfg.torque_src : 2'h0;
		end
	end

	assign state_o = state_q;

	// ****************************************
	// checks
	// ****************************************
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	sequence s_mag_done;
		(state_q == hbs_pkg::HBS_ST_MAG) && seq_done && !stop_req && !coast_stop_command_i;
	endsequence

	excite_before_open_a: assert property (
		(state_q == hbs_pkg::HBS_ST_OPEN) && ($past(state_q) == hbs_pkg::HBS_ST_MAG)
			|-> $past(seq_done))
		else $error("brake opened before excitation finished");

	open_hold_a: assert property (
		s_mag_done ##0 seq_en |=> drive_o.hold_zero && !drive_o.ramp_en)
		else $error("no standstill hold during opening delay");

	stop_decel_a: assert property (
		$rose(state_q == hbs_pkg::HBS_ST_CLOSE) |-> $past(state_q) == hbs_pkg::HBS_ST_STOP)
		else $error("brake close without deceleration");

	mon_start_a: assert property (
		mon_start && !coast_stop_command_i |=> mon_busy || mon_done)
		else $error("monitor timer not started");

	first_timer_a: assert property (
		st_stop && stand_done && seq_en && !coast_stop_command_i
			|=> state_q == hbs_pkg::HBS_ST_CLOSE ##1 drive_o.motor_on)
		else $error("brake close not taken on timer expiry");

	close_keep_a: assert property (
		(state_q == hbs_pkg::HBS_ST_CLOSE) && !seq_done && !coast_stop_command_i
			|=> drive_o.motor_on)
		else $error("motor off before closing delay");

	coast_close_a: assert property (
		coast_stop_command_i && !fopen_w && (cfg.mode != hbs_pkg::HBS_MODE_OPEN)
			|=> !brake_open_o && !brake_route_o && !drive_o.motor_on)
		else $error("coast stop did not close brake");

	mode_off_a: assert property (
		(cfg.mode == hbs_pkg::HBS_MODE_OFF) && !fopen_w |=> !brake_open_o && !brake_route_o)
		else $error("brake opened while function disabled");

	force_open_a: assert property (
		fopen_w && !fclose_w |=> brake_open_status_bit_o)
		else $error("forced open ignored");

	force_close_a: assert property (
		fclose_w |=> !brake_open_o && !brake_route_o && !brake_open_status_bit_o)
		else $error("forced close ignored");

	status_a: assert property (
		brake_open_status_bit_o == (brake_open_o || brake_route_o))
		else $error("status bit differs from brake command");

	slip_a: assert property (
		slip_comp_en_o == ($past(cfg.start_freq) != 8'h00))
		else $error("slip compensation enable wrong");

endmodule

// ---- design/hbs_params.svh ----
// constants of the holding brake sequencer: reset values, timing counts
// Summary of operation
// - on run, energize motor; open brake only after excitation delay fully elapsed; the sequencer opens it at once on a stop during excitation
// - after brake open, hold zero speed until opening delay expires, then accelerate
// - ramp or quick stop decelerates to zero before brake close and motor off
// - setpoint below threshold starts monitor timer; actual below starts pulse-cancel timer
// - brake close commanded when first of monitor or pulse-cancel timer expires
// - after brake close, motor stays energized for closing delay, then switches off
// - coast stop closes brake at once, regardless of speed or timers, unless mode 2 or forced open keeps it open
// - mode 0 disabled (reset), 1 sequenced, 2 always open, 3 sequenced routed
// - opening delay configurable, reset 0.1 s, set above relay plus release time
// - closing delay configurable, reset 0.1 s, set above relay plus closing time
// - readable status bit mirrors the internal brake-open command
// - selectable forced-open input opens brake unless forced close is active; source resets to 0
// - selectable forced-close input closes brake unconditionally; source resets to 0
// - standstill speed threshold configurable, reset 20 rpm
// - standstill monitoring time configurable, reset 300 s
// - pulse-cancel delay configurable, reset 0.01 s
// - start frequency resets to 0 %; any nonzero value enables slip compensation
// - torque setpoint source for brake start in vector control, reset 0
`ifndef HBS_PARAMS_SVH
`define HBS_PARAMS_SVH

// ****************************************
// clock and time base
// ****************************************
`define HBS_CLK_PERIOD_NS 25
`define HBS_TICK_US 1000
`define HBS_TICK_CYCLES ((`HBS_TICK_US * 1000) / `HBS_CLK_PERIOD_NS)

// ****************************************
// configuration reset values (times in ms)
// ****************************************
`define HBS_MODE_RST 2'h0
`define HBS_CTRL_MODE_RST 8'h00
`define HBS_EXCITE_RST 20'h0_0000
`define HBS_OPEN_DLY_RST 20'h0_0064
`define HBS_CLOSE_DLY_RST 20'h0_0064
`define HBS_MON_TIME_RST 20'h4_93E0
`define HBS_PC_DLY_RST 20'h0_000A
`define HBS_THRESH_RST 16'h0014
`define HBS_SRC_RST 2'h0
`define HBS_START_FREQ_RST 8'h00
`define HBS_VECTOR_MIN 8'h14

`endif

// ---- design/hbs_pkg.sv ----
// types of the holding brake sequencer
package hbs_pkg;

	typedef enum logic [1:0] {
		HBS_MODE_OFF = 2'b00,
		HBS_MODE_SEQ = 2'b01,
		HBS_MODE_OPEN = 2'b10,
		HBS_MODE_ROUTED = 2'b11
	} hbs_mode_e;

	typedef enum logic [2:0] {
		HBS_ST_IDLE = 3'b000,
		HBS_ST_MAG = 3'b001,
		HBS_ST_OPEN = 3'b010,
		HBS_ST_RUN = 3'b011,
		HBS_ST_STOP = 3'b100,
		HBS_ST_CLOSE = 3'b101
	} hbs_state_e;

	typedef struct packed {
		hbs_mode_e mode;
		logic [7:0] ctrl_mode;
		logic [19:0] excite_ms;
		logic [19:0] open_ms;
		logic [19:0] close_ms;
		logic [19:0] mon_ms;
		logic [19:0] pc_ms;
		logic [15:0] thresh_rpm;
		logic [1:0] fopen_src;
		logic [1:0] fclose_src;
		logic [7:0] start_freq;
		logic [1:0] torque_src;
	} hbs_cfg_s;

	typedef struct packed {
		logic motor_on;
		logic hold_zero;
		logic ramp_en;
		logic decel;
	} hbs_drv_s;

endpackage

// ---- design/hbs_timer.sv ----
// millisecond delay counter with its own prescaler
`timescale 1ns/100ps
module hbs_timer #(
	parameter int WIDTH = 20,
	parameter int TICK_CYCLES = 40000
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic start_i,
	input wire logic clear_i,
	input wire logic [WIDTH-1:0] dur_i,
	output logic busy_o,
	output logic done_o
);

	// a one-cycle prescaler never wraps, so refuse it at build time
	if (WIDTH < 1 || TICK_CYCLES < 2) begin
		$error("hbs_timer: bad parameters");
	end

	localparam int PW = $clog2(TICK_CYCLES);

	logic [PW-1:0] pre_q;
	logic [WIDTH-1:0] cnt_q;
	wire tick = (pre_q == PW'(TICK_CYCLES - 1));

	// reload on every start not overridden by clear, count whole ms after it
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			pre_q <= '0;
			cnt_q <= '0;
			busy_o <= 1'b0;
			done_o <= 1'b0;
		end else if (clear_i) begin
			busy_o <= 1'b0;
			done_o <= 1'b0;
		end else if (start_i) begin
			pre_q <= '0;
			cnt_q <= dur_i;
			busy_o <= 1'b1;
			done_o <= 1'b0;
		end else if (busy_o) begin
			if (cnt_q == '0) begin
				busy_o <= 1'b0;
				done_o <= 1'b1;
			end else if (tick) begin
				pre_q <= '0;
				cnt_q <= cnt_q - WIDTH'(1);
			end else begin
				pre_q <= pre_q + PW'(1);
			end
		end
	end

endmodule

// ---- testbench/hbs_motor_model.sv ----
// behavioural motor, power stage and holding brake facing the sequencer
`timescale 1ns/100ps
module hbs_motor_model #(
	parameter int RELEASE_CYCLES = 6,
	parameter int STEP = 8
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire hbs_pkg::hbs_drv_s drive_i,
	input wire logic brake_cmd_i,
	input wire logic signed [15:0] target_i,
	output logic signed [15:0] speed_o
);
	int rel_cnt;
	logic signed [15:0] aim;
	// ****************************************
	// brake mechanics
	// ****************************************
	// release time below delays
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			rel_cnt <= 0;
		end else if (!brake_cmd_i) begin
			rel_cnt <= 0;
		end else if (rel_cnt < RELEASE_CYCLES) begin
			rel_cnt <= rel_cnt + 1;
		end
	end
	// ****************************************
	// shaft speed
	// ****************************************
	// a held brake pins the shaft, so a too early ramp shows up as no movement
	assign aim = (drive_i.ramp_en && rel_cnt == RELEASE_CYCLES) ? target_i : 16'sh0000;
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			speed_o <= 16'sh0000;
		end else if (speed_o < aim - STEP) begin
			speed_o <= speed_o + 16'(STEP);
		end else if (speed_o > aim + STEP) begin
			speed_o <= speed_o - 16'(STEP);
		end else begin
			speed_o <= aim;
		end
	end
endmodule

// ---- testbench/hbs_sequencer_tb.sv ----
// self-checking bench of the holding brake sequencer
`timescale 1ns/100ps
module hbs_sequencer_tb;
	localparam int TICK = 4;
	logic clk_i, rst_i, cfg_load_i, run_cmd_i, ramp_stop_command_i, quick_stop_command_i;
	logic coast_stop_command_i, slip_comp_en_o, brake_any;
	logic brake_open_o, brake_route_o, brake_open_status_bit_o;
	hbs_pkg::hbs_cfg_s cfg_i;
	logic signed [15:0] speed_setpoint_i, speed_actual;
	logic [2:0] aux_pin_i;
	hbs_pkg::hbs_drv_s drive_o;
	logic [7:0] brake_start_frequency_o;
	logic [1:0] brake_start_torque_source_o;
	hbs_pkg::hbs_state_e state_o;
	int n_mismatch = 0;
	int compares = 0;
	int n;
	assign brake_any = brake_open_o | brake_route_o | (cfg_i.mode == hbs_pkg::HBS_MODE_OFF);
	hbs_sequencer #(.TICK_CYCLES(TICK)) u_hbs_sequencer (.clk_i(clk_i), .rst_i(rst_i),
		.cfg_load_i(cfg_load_i), .cfg_i(cfg_i), .run_cmd_i(run_cmd_i),
		.ramp_stop_command_i(ramp_stop_command_i), .quick_stop_command_i(quick_stop_command_i),
		.coast_stop_command_i(coast_stop_command_i), .speed_setpoint_i(speed_setpoint_i),
		.speed_actual_i(speed_actual), .aux_pin_i(aux_pin_i), .drive_o(drive_o),
		.brake_open_o(brake_open_o), .brake_route_o(brake_route_o),
		.brake_open_status_bit_o(brake_open_status_bit_o), .slip_comp_en_o(slip_comp_en_o),
		.brake_start_frequency_o(brake_start_frequency_o),
		.brake_start_torque_source_o(brake_start_torque_source_o), .state_o(state_o));
	hbs_motor_model u_hbs_motor_model (.clk_i(clk_i), .rst_i(rst_i), .drive_i(drive_o),
		.brake_cmd_i(brake_any), .target_i(speed_setpoint_i), .speed_o(speed_actual));
	// ****************************************
	// access tasks
	// ****************************************
	task automatic final_report();
		$display("compares %0d mismatches %0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("Error %s expected %0h seen %0h", what, exp, seen);
		end
	endtask
	task automatic in_range(input string what, input int v, input int lo, input int hi);
		check(what, 32'(v >= lo && v <= hi), 32'h0000_0001);
	endtask
	task automatic tick(input int k);
		repeat (k) @(negedge clk_i);
	endtask
	task automatic load();
		cfg_load_i = 1'b1;
		tick(1);
		cfg_load_i = 1'b0;
		tick(2);
	endtask
	task automatic wait_state(input hbs_pkg::hbs_state_e st, output int cnt);
		cnt = 0;
		while (state_o !== st) begin
			tick(1);
			cnt++;
			if (cnt > 2000) begin
				n_mismatch++;
				$display("Error state %0d expected reached seen timeout", st);
				final_report();
			end
		end
	endtask
	task automatic run_up();
		run_cmd_i = 1'b1;
		tick(1);
		run_cmd_i = 1'b0;
		wait_state(hbs_pkg::HBS_ST_RUN, n);
		tick(20);
	endtask
	task automatic coast();
		coast_stop_command_i = 1'b1;
		tick(1);
		coast_stop_command_i = 1'b0;
	endtask
	initial begin
		clk_i = 1'b0;
		forever #12.5 clk_i = ~clk_i;
	end
	// ****************************************
	// test sequence
	// ****************************************
	initial begin
		rst_i = 1'b1;
		{cfg_load_i, run_cmd_i, ramp_stop_command_i, quick_stop_command_i} = 4'h0;
		coast_stop_command_i = 1'b0;
		cfg_i = '0;
		aux_pin_i = 3'h0;
		speed_setpoint_i = 16'sh0064;
		repeat (6) @(posedge clk_i);
		@(negedge clk_i);
		check("state", state_o, hbs_pkg::HBS_ST_IDLE);
		check("outputs", {brake_open_o, brake_route_o, drive_o, slip_comp_en_o}, '0);
		rst_i = 1'b0;
		tick(2);
		run_up();
		check("brake_off_mode", brake_open_o | brake_route_o, 1'b0);
		ramp_stop_command_i = 1'b1;
		tick(1);
		wait_state(hbs_pkg::HBS_ST_IDLE, n);
		ramp_stop_command_i = 1'b0;
		in_range("default_pc", n, 10 * TICK + 10, 10 * TICK + 16);
		$display("test default_mode done");
		cfg_i.mode = hbs_pkg::HBS_MODE_SEQ;
		cfg_i.excite_ms = 20'h0_0002;
		cfg_i.open_ms = 20'h0_0003;
		cfg_i.close_ms = 20'h0_0003;
		cfg_i.mon_ms = 20'h0_0032;
		cfg_i.pc_ms = 20'h0_0002;
		cfg_i.thresh_rpm = 16'h0014;
		cfg_i.start_freq = 8'h05;
		cfg_i.torque_src = 2'h2;
		cfg_i.ctrl_mode = 8'h14;
		load();
		run_cmd_i = 1'b1;
		tick(1);
		run_cmd_i = 1'b0;
		check("mag", {state_o, drive_o.motor_on, brake_open_o}, {3'h1, 2'h2});
		wait_state(hbs_pkg::HBS_ST_OPEN, n);
		in_range("excite_time", n, 2 * TICK, 2 * TICK + 4);
		check("open_cmd", {brake_open_o, brake_open_status_bit_o}, 2'h3);
		check("hold", {drive_o.hold_zero, drive_o.ramp_en}, 2'h2);
		check("start_freq", {brake_start_frequency_o, slip_comp_en_o}, 9'h00B);
		check("torque_src", brake_start_torque_source_o, 2'h2);
		wait_state(hbs_pkg::HBS_ST_RUN, n);
		in_range("open_time", n, 3 * TICK, 3 * TICK + 4);
		check("ramp", {drive_o.ramp_en, brake_start_frequency_o}, 9'h100);
		tick(20);
		ramp_stop_command_i = 1'b1;
		tick(1);
		check("decel", {state_o, drive_o.decel, brake_open_o}, {3'h4, 2'h3});
		wait_state(hbs_pkg::HBS_ST_CLOSE, n);
		ramp_stop_command_i = 1'b0;
		in_range("pc_path", n, 2 * TICK + 10, 40);
		check("standstill", 32'(speed_actual < 16'sh0014), 32'h0000_0001);
		check("close_cmd", {brake_open_o, drive_o.motor_on}, 2'h1);
		wait_state(hbs_pkg::HBS_ST_IDLE, n);
		in_range("close_time", n, 3 * TICK, 3 * TICK + 4);
		check("motor_off", drive_o.motor_on, 1'b0);
		$display("test ramp_stop done");
		cfg_i.mon_ms = 20'h0_0001;
		cfg_i.pc_ms = 20'h0_003C;
		load();
		run_up();
		quick_stop_command_i = 1'b1;
		speed_setpoint_i = 16'sh0000;
		tick(1);
		wait_state(hbs_pkg::HBS_ST_CLOSE, n);
		quick_stop_command_i = 1'b0;
		in_range("mon_path", n, TICK - 1, TICK + 4);
		wait_state(hbs_pkg::HBS_ST_IDLE, n);
		speed_setpoint_i = 16'sh0064;
		$display("test quick_stop done");
		run_up();
		coast();
		check("coast", {state_o, brake_open_o, drive_o.motor_on}, '0);
		$display("test coast_stop done");
		cfg_i.mode = hbs_pkg::HBS_MODE_ROUTED;
		cfg_i.ctrl_mode = 8'h03;
		load();
		run_cmd_i = 1'b1;
		tick(1);
		run_cmd_i = 1'b0;
		wait_state(hbs_pkg::HBS_ST_OPEN, n);
		check("routed", {brake_route_o, brake_open_o, brake_open_status_bit_o,
			brake_start_torque_source_o}, {3'h5, 2'h0});
		coast();
		cfg_i.mode = hbs_pkg::HBS_MODE_OPEN;
		load();
		check("always_open", brake_open_o, 1'b1);
		coast();
		check("open_on_coast", brake_open_o, 1'b1);
		$display("test modes done");
		cfg_i.mode = hbs_pkg::HBS_MODE_SEQ;
		cfg_i.fopen_src = 2'h1;
		load();
		aux_pin_i = 3'h1;
		tick(5);
		check("forced_open", brake_open_o, 1'b1);
		cfg_i.fclose_src = 2'h2;
		load();
		aux_pin_i = 3'h3;
		tick(5);
		check("forced_close", brake_open_o, 1'b0);
		$display("test forced done");
		final_report();
	end
endmodule
